// ---- src/adc_ctrl_consts.vh ----
// constants for the serial converter control block
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// multiplexer variants, by number of single-ended inputs
`define VARIANT_1CH      4'h1
`define VARIANT_2CH      4'h2
`define VARIANT_4CH      4'h4
`define VARIANT_8CH      4'h8

// address bits that follow the start bit, per variant
`define ADDR_BITS_2CH    3'h2
`define ADDR_BITS_4CH    3'h3
`define ADDR_BITS_8CH    3'h4

// position of each address bit in arrival order
`define ADDR_POS_SGL     3'h0
`define ADDR_POS_ODD     3'h1
`define ADDR_POS_SEL1    3'h2
`define ADDR_POS_SEL0    3'h3

// result word
`define RESULT_ZERO      8'h00
`define SAR_MSB_TRIAL    8'h80
`define BIT_IDX_MSB      3'h7
`define BIT_IDX_LSB      3'h0
`define BIT_IDX_FIRST_LSB_OUT 3'h1

`endif

// ---- src/mux_addr_decode.v ----
// multiplexer address decoder: positive and negative terminal selection
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"

module mux_addr_decode
#(
   parameter [3:0] CHANNELS = `VARIANT_8CH
)
(
   // address fields
   input  wire       single_or_differential_sel,
   input  wire       odd_sign,
   input  wire       select_one,
   input  wire       select_zero,
   // terminal assignment
   output reg  [2:0] pos_chan,
   output reg  [2:0] neg_chan,
   output reg        neg_common
);

   always @*
   begin
      pos_chan   = 3'h0;
      neg_chan   = 3'h1;
      neg_common = 1'b0;
      if (CHANNELS == `VARIANT_8CH)
      begin
         pos_chan = {select_one, select_zero, odd_sign};
         neg_chan = {select_one, select_zero, ~odd_sign};
      end
      else if (CHANNELS == `VARIANT_4CH)
      begin
         pos_chan = {1'b0, select_one, odd_sign};
         neg_chan = {1'b0, select_one, ~odd_sign};
      end
      else if (CHANNELS == `VARIANT_2CH)
      begin
         pos_chan = {2'h0, odd_sign};
         neg_chan = {2'h0, ~odd_sign};
      end
      // single-ended: the common input is the negative terminal
      if (CHANNELS != `VARIANT_1CH && single_or_differential_sel)
      begin
         neg_chan   = 3'h0;
         neg_common = 1'b1;
      end
   end

endmodule

// ---- src/serial_adc_mux_addressing.v ----
// serial 8-bit converter control: address reception, conversion sequence, serial output
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"

// Summary of operation
// - a conversion takes eight converter clock periods after addressing ends
// - negative input at or above positive input gives an all-zero result
// - msb-first output bits are live comparator decisions, taken after a settling delay; lsb-first bits are read back from the register
// - four-channel: bit after odd/sign loads select one; select zero forced one
// - two-channel: bit after mode loads odd/sign; select zero 0, select one 1
// - converted value is always positive terminal minus negative terminal
// - input configuration is fixed from the address before conversion starts
// - differential pairs are adjacent channels; sign picks the positive member
// - address arrives serially on data-in; single-pair variant takes none
// - eight-channel single-ended or pseudo-differential uses common as negative
// - eight-channel single-ended channel is 4*sel1 + 2*sel0 + odd/sign
// - data-in sampled on rising clock edges; first one is the start bit
// - half-period settle after address, data-in ignored, leading zero driven
// - result bits leave on falling clock edges, most significant first
// - chip select high clears all state except the terminal selection; new conversion needs a new address
module serial_adc_mux_addressing
#(
   parameter [3:0] CHANNELS = `VARIANT_8CH
)
(
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // serial link pins
   input  wire       cs_n,
   input  wire       conv_clk,
   input  wire       serial_in_line,
   output reg        data_out,
   output reg        data_out_en,
   // analog front end
   input  wire       comparator_high,
   input  wire       neg_not_below_pos,
   output reg  [7:0] approximation_register,
   output reg  [2:0] pos_chan,
   output reg  [2:0] neg_chan,
   output reg        neg_common,
   // status
   output reg        conv_busy
);

   localparam [2:0] ST_WAIT_START = 3'h0;
   localparam [2:0] ST_ADDRESS    = 3'h1;
   localparam [2:0] ST_SETTLE     = 3'h2;
   localparam [2:0] ST_CONVERT    = 3'h3;
   localparam [2:0] ST_LSB_OUT    = 3'h4;
   localparam [2:0] ST_DONE       = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the third clock stage is only for edge finding

   reg       cs_s1_reg, cs_s2_reg;
   reg       ck_s1_reg, ck_s2_reg, ck_s3_reg;
   reg       di_s1_reg, di_s2_reg;
   reg       cmp_s1_reg, cmp_s2_reg;
   reg       ng_s1_reg, ng_s2_reg;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cs_s1_reg  <= 1'b1;
         cs_s2_reg  <= 1'b1;
         ck_s1_reg  <= 1'b0;
         ck_s2_reg  <= 1'b0;
         ck_s3_reg  <= 1'b0;
         di_s1_reg  <= 1'b0;
         di_s2_reg  <= 1'b0;
         cmp_s1_reg <= 1'b0;
         cmp_s2_reg <= 1'b0;
         ng_s1_reg  <= 1'b0;
         ng_s2_reg  <= 1'b0;
      end
      else
      begin
         cs_s1_reg  <= cs_n;
         cs_s2_reg  <= cs_s1_reg;
         ck_s1_reg  <= conv_clk;
         ck_s2_reg  <= ck_s1_reg;
         ck_s3_reg  <= ck_s2_reg;
         di_s1_reg  <= serial_in_line;
         di_s2_reg  <= di_s1_reg;
         cmp_s1_reg <= comparator_high;
         cmp_s2_reg <= cmp_s1_reg;
         ng_s1_reg  <= neg_not_below_pos;
         ng_s2_reg  <= ng_s1_reg;
      end
   end

   wire ck_rise = ck_s2_reg & ~ck_s3_reg;
   wire ck_fall = ~ck_s2_reg & ck_s3_reg;

   ////////////////////////////////////////////////////////////////////////////
   // address fields and decode

   reg  [2:0] state_reg;
   reg  [2:0] cnt_reg;
   reg        sgl_reg, odd_reg, sel1_reg, sel0_reg;
   wire [2:0] dec_pos, dec_neg;
   wire       dec_common;

   wire [2:0] addr_bits = (CHANNELS == `VARIANT_8CH) ? `ADDR_BITS_8CH :
                          (CHANNELS == `VARIANT_4CH) ? `ADDR_BITS_4CH : `ADDR_BITS_2CH;
   wire       last_addr = (cnt_reg == addr_bits - 3'h1);

   mux_addr_decode #(.CHANNELS(CHANNELS)) u_decode
   (
      .single_or_differential_sel (sgl_reg),
      .odd_sign                   (odd_reg),
      .select_one                 (sel1_reg),
      .select_zero                (sel0_reg),
      .pos_chan                   (dec_pos),
      .neg_chan                   (dec_neg),
      .neg_common                 (dec_common)
   );

   // a decision is forced low when the inputs are reversed, so the word ends at zero
   wire decision = cmp_s2_reg & ~ng_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg              <= ST_WAIT_START;
         cnt_reg                <= 3'h0;
         sgl_reg                <= 1'b0;
         odd_reg                <= 1'b0;
         sel1_reg               <= 1'b0;
         sel0_reg               <= 1'b0;
         approximation_register <= `RESULT_ZERO;
         pos_chan               <= 3'h0;
         neg_chan               <= 3'h0;
         neg_common             <= 1'b0;
         data_out               <= 1'b0;
         data_out_en            <= 1'b0;
         conv_busy              <= 1'b0;
      end
      else if (cs_s2_reg)
      begin
         // chip select high wipes everything except the terminal selection and releases data-out
         state_reg              <= ST_WAIT_START;
         cnt_reg                <= 3'h0;
         sgl_reg                <= 1'b0;
         odd_reg                <= 1'b0;
         sel1_reg               <= 1'b0;
         sel0_reg               <= 1'b0;
         approximation_register <= `RESULT_ZERO;
         data_out               <= 1'b0;
         data_out_en            <= 1'b0;
         conv_busy              <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_WAIT_START:
            begin
               if (CHANNELS == `VARIANT_1CH)
               begin
                  // fixed pair, no address: settle starts on the first rising edge
                  if (ck_rise)
                     state_reg <= ST_SETTLE;
               end
               else if (ck_rise && di_s2_reg)
               begin
                  state_reg <= ST_ADDRESS;
                  cnt_reg   <= 3'h0;
                  sel1_reg  <= (CHANNELS == `VARIANT_2CH);
                  sel0_reg  <= (CHANNELS == `VARIANT_4CH);
               end
            end
            ST_ADDRESS:
            begin
               if (ck_rise)
               begin
                  case (cnt_reg)
                     `ADDR_POS_SGL:  sgl_reg  <= di_s2_reg;
                     `ADDR_POS_ODD:  odd_reg  <= di_s2_reg;
                     `ADDR_POS_SEL1: sel1_reg <= di_s2_reg;
                     `ADDR_POS_SEL0: sel0_reg <= di_s2_reg;
                     default:        sgl_reg  <= sgl_reg;
                  endcase
                  cnt_reg <= cnt_reg + 3'h1;
                  if (last_addr)
                     state_reg <= ST_SETTLE;
               end
            end
            ST_SETTLE:
            begin
               // half a period of settling, then the leading zero; data-in no longer read
               if (ck_fall)
               begin
                  pos_chan               <= dec_pos;
                  neg_chan               <= dec_neg;
                  neg_common             <= dec_common;
                  data_out               <= 1'b0;
                  data_out_en            <= 1'b1;
                  conv_busy              <= 1'b1;
                  approximation_register <= `SAR_MSB_TRIAL;
                  cnt_reg                <= `BIT_IDX_MSB;
                  state_reg              <= ST_CONVERT;
               end
            end
            ST_CONVERT:
            begin
               // trial bit was set a full period ago, which covers comparator response
               if (ck_fall)
               begin
                  approximation_register[cnt_reg] <= decision;
                  if (cnt_reg != `BIT_IDX_LSB)
                     approximation_register[cnt_reg - 3'h1] <= 1'b1;
                  data_out <= decision;
                  cnt_reg  <= cnt_reg - 3'h1;
                  if (cnt_reg == `BIT_IDX_LSB)
                  begin
                     cnt_reg   <= `BIT_IDX_FIRST_LSB_OUT;
                     state_reg <= (CHANNELS == `VARIANT_1CH) ? ST_DONE : ST_LSB_OUT;
                  end
               end
            end
            ST_LSB_OUT:
            begin
               if (ck_rise)
                  conv_busy <= 1'b0;
               if (ck_fall)
               begin
                  // the lsb was the last msb-first bit, so it is not sent twice
                  data_out <= approximation_register[cnt_reg];
                  cnt_reg  <= cnt_reg + 3'h1;
                  if (cnt_reg == `BIT_IDX_MSB)
                     state_reg <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               if (ck_rise)
                  conv_busy <= 1'b0;
               if (ck_fall)
                  data_out <= 1'b0;
            end
            default:
            begin
               state_reg <= ST_WAIT_START;
            end
         endcase
      end
   end

endmodule

// ---- tb/adc_link_props.sv ----
// concurrent checks on the converter control ports
`timescale 1ns/1ns
module adc_link_props
#(
   parameter [3:0] CHANNELS = 4'h8
)
(
   // clock and reset
   input wire       clk,
   input wire       rst,
   // link pins
   input wire       cs_n,
   input wire       conv_clk,
   input wire       serial_in_line,
   input wire       data_out,
   input wire       data_out_en,
   // analog front end and status
   input wire       comparator_high,
   input wire       neg_not_below_pos,
   input wire [7:0] approximation_register,
   input wire [2:0] pos_chan,
   input wire [2:0] neg_chan,
   input wire       neg_common,
   input wire       conv_busy
);
   reg [7:0] busy_cnt_reg;
   reg [3:0] neg_cnt_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////
   // long spans are counted here so repetitions stay short
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy_cnt_reg <= 8'h00;
         neg_cnt_reg  <= 4'h0;
      end
      else
      begin
         busy_cnt_reg <= conv_busy ? busy_cnt_reg + 8'h01 : 8'h00;
         neg_cnt_reg  <= !neg_not_below_pos ? 4'h0 : neg_cnt_reg + {3'h0, neg_cnt_reg != 4'hf};
      end
   end
   ////////////////
   sequence cs_idle_s;
      cs_n [*4];
   endsequence
   sequence sending_s;
      !cs_n [*3] ##0 data_out_en;
   endsequence
   cs_clear_a: assert property (cs_idle_s |=> !data_out_en && !conv_busy && approximation_register == 8'h00)
      else $error("state not cleared while deselected");
   en_keep_a: assert property (sending_s |=> data_out_en)
      else $error("output enable dropped while selected");
   settle_start_a: assert property ($rose(data_out_en) |-> $rose(conv_busy) && !data_out && approximation_register == 8'h80)
      else $error("conversion start misaligned");
   terms_pick_a: assert property ($rose(conv_busy) |-> (neg_common ? neg_chan == 3'h0 : neg_chan == (pos_chan ^ 3'h1)))
      else $error("negative terminal wrong");
   terms_hold_a: assert property (conv_busy && $past(conv_busy) |-> $stable({pos_chan, neg_chan, neg_common}))
      else $error("terminals changed mid conversion");
   busy_len_a: assert property ($fell(conv_busy) && !$past(cs_n, 3) && !$past(cs_n, 4) |-> busy_cnt_reg inside {[66:70]})
      else $error("conversion length wrong");
   neg_zero_a: assert property (neg_cnt_reg == 4'hf && conv_busy |-> !data_out)
      else $error("nonzero bit with reversed inputs");
   out_edge_a: assert property ($changed(data_out) && !cs_n && !$past(cs_n, 3) |-> !$past(conv_clk, 2))
      else $error("data out moved off a falling edge");
endmodule
bind serial_adc_mux_addressing adc_link_props #(.CHANNELS(CHANNELS)) i_props (.clk, .rst, .cs_n, .conv_clk,
   .serial_in_line, .data_out, .data_out_en, .comparator_high, .neg_not_below_pos,
   .approximation_register, .pos_chan, .neg_chan, .neg_common, .conv_busy);

// ---- tb/host_link.sv ----
// host model: chip select, converter clock, data-in, reads data-out
`timescale 1ns/1ns
module host_link
(
   input  wire clk,
   output reg  cs_n,
   output reg  conv_clk,
   output reg  serial_in_line,
   input  wire data_out,
   input  wire data_out_en
);
   initial
   begin
      cs_n = 1'b1;
      conv_clk = 1'b0;
      serial_in_line = 1'b0;
   end
   ////////////////
   // 50 percent duty, 160 ns high, clock rests low between frames
   task frame(input integer lead, input [3:0] addr, input integer cycles, output reg [21:0] rx);
      integer i;
      reg     di;
   begin
      rx = 22'h0;
      di = 1'b0;
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < lead + 5 + cycles; i = i + 1)
      begin
         if (i < lead)
            di = 1'b0;
         else if (i == lead)
            di = 1'b1;
         else if (i < lead + 5)
            di = addr[lead + 4 - i];
         else
            di = ~di;
         serial_in_line = di;
         repeat (4) @(negedge clk);
         conv_clk = 1'b1;
         repeat (4) @(negedge clk);
         // undriven line is read as one, never as the last bit
         rx = {rx[20:0], data_out_en ? data_out : 1'b1};
         conv_clk = 1'b0;
      end
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
   end
   endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the serial converter control block
`timescale 1ns/1ns
module testbench;
   reg         clk;
   reg         rst;
   reg         comparator_high;
   reg         neg_not_below_pos;
   reg  [7:0]  vin;
   reg  [21:0] rx;
   wire        cs_n, conv_clk, serial_in_line, data_out, data_out_en, neg_common, conv_busy;
   wire [7:0]  approximation_register;
   wire [2:0]  pos_chan, neg_chan;
   wire [6:0]  terms_quad, terms_pair, terms_single;
   integer     n_mismatch, comparisons, k;
   serial_adc_mux_addressing #(.CHANNELS(4'h8)) i_dut (.clk, .rst, .cs_n, .conv_clk,
      .serial_in_line, .data_out, .data_out_en, .comparator_high, .neg_not_below_pos,
      .approximation_register, .pos_chan, .neg_chan, .neg_common, .conv_busy);
   host_link i_host (.clk, .cs_n, .conv_clk, .serial_in_line, .data_out, .data_out_en);
   // smaller variants share the host pins; only their terminal choice is compared
   serial_adc_mux_addressing #(.CHANNELS(4'h4)) i_dut_quad (.clk, .rst, .cs_n, .conv_clk, .serial_in_line,
      .data_out(), .data_out_en(), .comparator_high, .neg_not_below_pos, .approximation_register(),
      .pos_chan(terms_quad[6:4]), .neg_chan(terms_quad[3:1]), .neg_common(terms_quad[0]), .conv_busy());
   serial_adc_mux_addressing #(.CHANNELS(4'h2)) i_dut_pair (.clk, .rst, .cs_n, .conv_clk, .serial_in_line,
      .data_out(), .data_out_en(), .comparator_high, .neg_not_below_pos, .approximation_register(),
      .pos_chan(terms_pair[6:4]), .neg_chan(terms_pair[3:1]), .neg_common(terms_pair[0]), .conv_busy());
   serial_adc_mux_addressing #(.CHANNELS(4'h1)) i_dut_single (.clk, .rst, .cs_n, .conv_clk, .serial_in_line,
      .data_out(), .data_out_en(), .comparator_high, .neg_not_below_pos, .approximation_register(),
      .pos_chan(terms_single[6:4]), .neg_chan(terms_single[3:1]), .neg_common(terms_single[0]), .conv_busy());
   always #20 clk = ~clk;
   // ideal comparator: the trial word settles towards vin
   always @(negedge clk) comparator_high <= (vin >= approximation_register);
   ////////////////
   task check(input string what, input [21:0] exp, input [21:0] got);
   begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   end
   endtask
   task run(input integer lead, input [3:0] addr, input [7:0] v, input reg rev);
      reg [7:0] e;
      reg [2:0] p;
      reg [2:0] q;
      reg [2:0] t;
   begin
      vin = v;
      neg_not_below_pos = rev;
      e = rev ? 8'h00 : v;
      p = {addr[1], addr[0], addr[2]};
      // four-channel takes mode, odd/sign, select one; two-channel takes mode, odd/sign
      q = {1'b0, addr[1], addr[2]};
      t = {2'h0, addr[2]};
      i_host.frame(lead, addr, 17, rx);
      check("stream", {5'h1f, 1'b0, e, e[1], e[2], e[3], e[4], e[5], e[6], e[7], 1'b0}, rx);
      check("terms", {15'h0, p, addr[3] ? 3'h0 : p ^ 3'h1, addr[3]}, {15'h0, pos_chan, neg_chan, neg_common});
      check("terms quad", {15'h0, q, addr[3] ? 3'h0 : q ^ 3'h1, addr[3]}, {15'h0, terms_quad});
      check("terms pair", {15'h0, t, addr[3] ? 3'h0 : t ^ 3'h1, addr[3]}, {15'h0, terms_pair});
      check("terms single", 22'h000002, {15'h0, terms_single});
   end
   endtask
   task wrap_up;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   ////////////////
   initial
   begin
      #400000;
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      vin = 8'h00;
      rx = 22'h0;
      neg_not_below_pos = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      for (k = 0; k < 16; k = k + 1)
         run(k % 3, k[3:0], {k[3:0], ~k[3:0]}, 1'b0);
      $display("test mux decode done");
      run(0, 4'h9, 8'h80, 1'b1);
      $display("test reversed inputs done");
      i_host.frame(1, 4'h8, 3, rx);
      check("abort", 22'h0001f8, rx);
      run(0, 4'h8, 8'hff, 1'b0);
      run(2, 4'h3, 8'h00, 1'b0);
      $display("test abort and limits done");
      wrap_up;
   end
endmodule
